// *** pkg/cfgl_pkg.sv ***
// Purpose: shared constants and types of the configuration loader
// Assumes: 25 MHz system clock, internal configuration clock near 1 MHz
// Notes:   mode codes are written {bit_a, bit_b, bit_c}
package cfgl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // mode pin codes
  localparam logic [2:0] MODE_CODE_SERIAL = 3'h0;
  localparam logic [2:0] MODE_CODE_UP     = 3'h1;
  localparam logic [2:0] MODE_CODE_DOWN   = 3'h3;
  localparam logic [2:0] MODE_CODE_PERIPH = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // stream layout
  localparam int          PREAMBLE_W   = 12;
  localparam logic [11:0] PREAMBLE     = 12'hff2;
  localparam int          LEN_W        = 24;
  localparam int          BYTE_W       = 8;
  localparam int          ADDR_W       = 16;
  localparam logic [15:0] ADDR_UP_RST  = 16'h0000;
  localparam logic [15:0] ADDR_DN_RST  = 16'hffff;
  // own payload length before going transparent; arbitrary plain default
  localparam logic [23:0] OWN_BITS_DEF = 24'h00_0400;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS  = 40;
  localparam int CONFIG_CLOCK_PERIOD_NS = 1000;
  // half period of the config clock, rounded down to whole cycles
  localparam int CONFIG_CLOCK_HALF_CYC  = CONFIG_CLOCK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    MODE_IDLE, MODE_SERIAL, MODE_UP, MODE_DOWN, MODE_PERIPH
  } cfgl_mode_t;

  typedef enum logic [1:0] {
    ST_SYNC, ST_LEN, ST_DATA, ST_DONE
  } cfgl_state_t;

endpackage : cfgl_pkg

// *** src/cfgl_byte_shifter.sv ***
// Purpose: byte to bit serialiser, least significant bit first
// Assumes: load only while empty, shift only while not empty
// Notes:   empty doubles as the ready term of the byte sources
`timescale 1ns/1ps
`default_nettype none
module cfgl_byte_shifter #(
  parameter int W = 8
) (
  input  wire logic         clk,      // system clock
  input  wire logic         rst_n,    // synchronised reset
  input  wire logic         load,     // take a new byte
  input  wire logic [W-1:0] load_data,// byte to serialise
  input  wire logic         shift,    // consume one bit
  output logic              bit_out,  // current bit
  output logic              empty     // no bit left
);

  logic [W-1:0] data;
  logic [3:0]   cnt;
  logic [W-1:0] next_data;
  logic [3:0]   next_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // next byte and bit count
  always_comb begin
    next_data = data;
    next_cnt  = cnt;
    if (load && cnt == 4'h0) begin
      next_data = load_data;
      next_cnt  = 4'(W);
    end else if (shift && cnt != 4'h0) begin
      next_data = data >> 1;
      next_cnt  = cnt - 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data <= '0;
      cnt  <= 4'h0;
    end else begin
      data <= next_data;
      cnt  <= next_cnt;
    end
  end

  assign bit_out = data[0];
  assign empty   = (cnt == 4'h0);

endmodule : cfgl_byte_shifter
`default_nettype wire

// *** src/cfgl_loader.sv ***
// Purpose: configuration loader, master serial/parallel and peripheral fetch
// Assumes: all pins synchronous to CLK; memory returns the addressed byte
// Notes:   the stream is echoed, then held high, then passed downstream
`timescale 1ns/1ps
`default_nettype none
module cfgl_loader #(
  parameter int          HALF_CYC = cfgl_pkg::CONFIG_CLOCK_HALF_CYC, // cycles per half clock
  parameter logic [23:0] OWN_BITS = cfgl_pkg::OWN_BITS_DEF   // own payload bits
) (
  input  wire logic        CLK,                  // system clock
  input  wire logic        RST_N,                // async reset, active low
  input  wire logic        MODE_SELECT_BIT_A,    // mode strap a
  input  wire logic        MODE_SELECT_BIT_B,    // mode strap b
  input  wire logic        MODE_SELECT_BIT_C,    // mode strap c
  output logic             CONFIG_CLOCK,         // internal config clock out
  input  wire logic        SERIAL_DIN,           // serial memory data
  output logic [15:0]      MEMORY_ADDRESS_BUS,   // parallel memory address
  input  wire logic [7:0]  BYTE_DATA_BUS,        // parallel or host byte
  input  wire logic        CHIP_SELECT_A_N,      // host select, active low
  input  wire logic        CHIP_SELECT_B_N,      // host select, active low
  input  wire logic        CHIP_SELECT_C,        // host select, active high
  input  wire logic        WRITE_STROBE_N,       // host write, active low
  output logic             READY_BUSY,           // high in peripheral mode when a byte fits
  output logic             SERIAL_DOUT,          // chain output
  output logic             COMPLETE_PROGRAM_PIN  // configuration complete
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode strap caught once after release
  cfgl_pkg::cfgl_mode_t mode;
  cfgl_pkg::cfgl_mode_t next_mode;
  logic                 mode_seen;
  logic [2:0]           pins;

  assign pins = {MODE_SELECT_BIT_A, MODE_SELECT_BIT_B, MODE_SELECT_BIT_C};

  always_comb begin
    next_mode = mode;
    if (!mode_seen) begin
      case (pins)
        cfgl_pkg::MODE_CODE_UP:     next_mode = cfgl_pkg::MODE_UP;
        cfgl_pkg::MODE_CODE_DOWN:   next_mode = cfgl_pkg::MODE_DOWN;
        cfgl_pkg::MODE_CODE_SERIAL: next_mode = cfgl_pkg::MODE_SERIAL;
        cfgl_pkg::MODE_CODE_PERIPH: next_mode = cfgl_pkg::MODE_PERIPH;
        default:                    next_mode = cfgl_pkg::MODE_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      mode      <= cfgl_pkg::MODE_IDLE;
      mode_seen <= 1'b0;
    end else begin
      mode      <= next_mode;
      mode_seen <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // config clock divider; a bit moves on each falling edge, except with the shifter empty outside serial mode
  cfgl_pkg::cfgl_state_t state;
  logic [7:0] div_cnt;
  logic [7:0] next_div_cnt;
  logic       next_config_clock;
  logic       active;
  logic       step;

  assign active = mode_seen && mode != cfgl_pkg::MODE_IDLE && state != cfgl_pkg::ST_DONE;
  assign step   = active && div_cnt == 8'(HALF_CYC - 1) && CONFIG_CLOCK;

  always_comb begin
    next_div_cnt = div_cnt;
    next_config_clock    = CONFIG_CLOCK;
    if (active) begin
      if (div_cnt == 8'(HALF_CYC - 1)) begin
        next_div_cnt = 8'h00;
        next_config_clock    = !CONFIG_CLOCK;
      end else begin
        next_div_cnt = div_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt      <= 8'h00;
      CONFIG_CLOCK <= 1'b0;
    end else begin
      div_cnt      <= next_div_cnt;
      CONFIG_CLOCK <= next_config_clock;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte sources: parallel memory and host writes share one shifter
  logic        par;
  logic        periph;
  logic        serial;
  logic        ws_prev;
  logic        sel;
  logic        ld;
  logic        sh_bit;
  logic        sh_empty;
  logic        take;
  logic        src_bit;
  logic [15:0] next_addr;

  assign par    = mode == cfgl_pkg::MODE_UP || mode == cfgl_pkg::MODE_DOWN;
  assign periph = mode == cfgl_pkg::MODE_PERIPH;
  assign serial = mode == cfgl_pkg::MODE_SERIAL;
  assign sel    = !CHIP_SELECT_A_N && !CHIP_SELECT_B_N && CHIP_SELECT_C;
  // a host byte is taken on the falling strobe only while the shifter is empty; strobes while busy are ignored
  assign ld = mode_seen && sh_empty && state != cfgl_pkg::ST_DONE
              && (par || (periph && sel && ws_prev && !WRITE_STROBE_N));
  // busy holds while an accepted byte shifts out
  assign READY_BUSY = periph && mode_seen && sh_empty && state != cfgl_pkg::ST_DONE;
  assign src_bit = serial ? SERIAL_DIN : sh_bit;
  assign take    = step && (serial || !sh_empty);

  cfgl_byte_shifter #(
    .W         (cfgl_pkg::BYTE_W)
  ) u_shift (
    .clk       (CLK),
    .rst_n     (rst_n),
    .load      (ld),
    .load_data (BYTE_DATA_BUS),
    .shift     (take && !serial),
    .bit_out   (sh_bit),
    .empty     (sh_empty)
  );

  // address start value set with the strap, then one step per fetched byte
  always_comb begin
    next_addr = MEMORY_ADDRESS_BUS;
    if (!mode_seen) begin
      next_addr = (next_mode == cfgl_pkg::MODE_DOWN) ? cfgl_pkg::ADDR_DN_RST
                                                     : cfgl_pkg::ADDR_UP_RST;
    end else if (ld && mode == cfgl_pkg::MODE_UP) begin
      next_addr = MEMORY_ADDRESS_BUS + 16'h0001;
    end else if (ld && mode == cfgl_pkg::MODE_DOWN) begin
      next_addr = MEMORY_ADDRESS_BUS - 16'h0001;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      MEMORY_ADDRESS_BUS <= cfgl_pkg::ADDR_UP_RST;
      ws_prev            <= 1'b1;
    end else begin
      MEMORY_ADDRESS_BUS <= next_addr;
      ws_prev            <= WRITE_STROBE_N;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame: preamble search, length count, own data, pass-through
  cfgl_pkg::cfgl_state_t next_state;
  logic [10:0] win;
  logic [10:0] next_win;
  logic [23:0] len;
  logic [23:0] next_len;
  logic [4:0]  len_cnt;
  logic [4:0]  next_len_cnt;
  logic [23:0] own_cnt;
  logic [23:0] next_own_cnt;
  logic [23:0] clk_cnt;
  logic [23:0] next_clk_cnt;
  logic        next_dout;
  logic        next_done;

  always_comb begin
    next_state   = state;
    next_win     = win;
    next_len     = len;
    next_len_cnt = len_cnt;
    next_own_cnt = own_cnt;
    next_clk_cnt = clk_cnt;
    next_dout    = SERIAL_DOUT;
    next_done    = COMPLETE_PROGRAM_PIN;
    if (take) begin
      // free-running count; a missed match waits for the wrap
      next_clk_cnt = clk_cnt + 24'h00_0001;
      case (state)
        cfgl_pkg::ST_SYNC: begin
          next_win  = {win[9:0], src_bit};
          next_dout = src_bit;
          if ({win, src_bit} == cfgl_pkg::PREAMBLE) begin
            next_state   = cfgl_pkg::ST_LEN;
            next_len_cnt = 5'h00;
          end
        end
        cfgl_pkg::ST_LEN: begin
          next_len     = {len[22:0], src_bit};
          next_dout    = src_bit;
          next_len_cnt = len_cnt + 5'h01;
          if (len_cnt == 5'(cfgl_pkg::LEN_W - 1)) begin
            next_state   = cfgl_pkg::ST_DATA;
            next_own_cnt = 24'h00_0000;
          end
        end
        cfgl_pkg::ST_DATA: begin
          if (own_cnt < OWN_BITS) begin
            next_own_cnt = own_cnt + 24'h00_0001;
            next_dout    = 1'b1;
          end else begin
            next_dout    = src_bit;
          end
          if (next_clk_cnt == len) begin
            next_state = cfgl_pkg::ST_DONE;
            next_done  = 1'b1;
            next_dout  = 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // reset drops everything back to the preamble search
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state                <= cfgl_pkg::ST_SYNC;
      win                  <= '0;
      len                  <= '0;
      len_cnt              <= 5'h00;
      own_cnt              <= 24'h00_0000;
      clk_cnt              <= 24'h00_0000;
      SERIAL_DOUT          <= 1'b1;
      COMPLETE_PROGRAM_PIN <= 1'b0;
    end else begin
      state                <= next_state;
      win                  <= next_win;
      len                  <= next_len;
      len_cnt              <= next_len_cnt;
      own_cnt              <= next_own_cnt;
      clk_cnt              <= next_clk_cnt;
      SERIAL_DOUT          <= next_dout;
      COMPLETE_PROGRAM_PIN <= next_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  a_mode_up_pins: assert property (!mode_seen ##1 mode_seen |->
    (mode == cfgl_pkg::MODE_UP) == ($past(pins) == 3'h1))
    else $error("ascending mode does not match straps");
  a_mode_down_pins: assert property (!mode_seen ##1 mode_seen |->
    (mode == cfgl_pkg::MODE_DOWN) == ($past(pins) == 3'h3))
    else $error("descending mode does not match straps");
  a_mode_serial_pins: assert property (!mode_seen ##1 mode_seen |->
    (mode == cfgl_pkg::MODE_SERIAL) == ($past(pins) == 3'h0))
    else $error("serial mode does not match straps");
  a_mode_periph_pins: assert property (!mode_seen ##1 mode_seen |->
    (mode == cfgl_pkg::MODE_PERIPH) == ($past(pins) == 3'h5))
    else $error("peripheral mode does not match straps");
  a_addr_up_walk: assert property (ld && mode == cfgl_pkg::MODE_UP |=>
    MEMORY_ADDRESS_BUS == $past(MEMORY_ADDRESS_BUS) + 16'h0001)
    else $error("ascending address did not increment");
  a_addr_down_walk: assert property (ld && mode == cfgl_pkg::MODE_DOWN |=>
    MEMORY_ADDRESS_BUS == $past(MEMORY_ADDRESS_BUS) - 16'h0001)
    else $error("descending address did not decrement");
  a_addr_start: assert property ($rose(mode_seen) |->
    MEMORY_ADDRESS_BUS == ((mode == cfgl_pkg::MODE_DOWN) ? 16'hffff : 16'h0000))
    else $error("address start value wrong");
  a_sync_echo: assert property (take && state != cfgl_pkg::ST_DATA
    && state != cfgl_pkg::ST_DONE |=> SERIAL_DOUT == $past(src_bit))
    else $error("header not echoed");
  a_own_high: assert property (take && state == cfgl_pkg::ST_DATA && own_cnt < OWN_BITS
    |=> SERIAL_DOUT)
    else $error("output low during own data");
  a_pass_through: assert property (take && state == cfgl_pkg::ST_DATA
    && own_cnt >= OWN_BITS && clk_cnt + 24'h00_0001 != len |=> SERIAL_DOUT == $past(src_bit))
    else $error("data not forwarded");
  a_serial_clock: assert property (serial && state != cfgl_pkg::ST_DONE
    |-> ##[1:300] $changed(CONFIG_CLOCK))
    else $error("config clock stalled");
  a_done_count: assert property ($rose(COMPLETE_PROGRAM_PIN) |-> clk_cnt == len
    && $past(state) == cfgl_pkg::ST_DATA)
    else $error("complete without length match");
  a_fall_step: assert property (take |=> !CONFIG_CLOCK)
    else $error("bit moved off the falling edge");
  a_busy_shift: assert property (periph && ld |=> (!READY_BUSY) [*8])
    else $error("ready while an accepted byte shifts");
  a_reset_clean: assert property ($rose(rst_n) |-> state == cfgl_pkg::ST_SYNC
    && clk_cnt == 24'h00_0000 && !COMPLETE_PROGRAM_PIN)
    else $error("reset left state behind");

  c_up_done: cover property (mode == cfgl_pkg::MODE_UP && $rose(COMPLETE_PROGRAM_PIN));
  c_serial_done: cover property (serial && $rose(COMPLETE_PROGRAM_PIN));
  c_host_byte: cover property (periph && ld ##1 !READY_BUSY);
  c_forward: cover property (take && state == cfgl_pkg::ST_DATA && own_cnt >= OWN_BITS);

endmodule : cfgl_loader
`default_nettype wire

// *** verification/cfgl_mem_model.sv ***
// Purpose: far-side memories of the loader, byte-wide and serial
// Assumes: the stream image is packed least significant bit first per byte
// Notes:   the serial pointer steps one edge after each config clock fall
`timescale 1ns/1ps
`default_nettype none
module cfgl_mem_model (
  input  wire logic        clk,        // system clock
  input  wire logic        oe_reset_n, // pointer reset, active low
  input  wire logic        ce_n,       // chip enable, active low
  input  wire logic        config_clock,       // config clock from the loader
  input  wire logic [71:0] image,      // whole stream
  input  wire logic [15:0] addr,       // parallel address
  output logic      [7:0]  data,       // parallel byte
  output logic             sdata       // serial bit
);
  logic [6:0] ptr;
  logic       config_clock_d;
  logic       sbit;

  ////////////////////////////////////////////////////////////////////////////
  // image sits at both ends so up and down fetches see one stream
  always_comb begin
    if (addr < 16'h0009) begin
      data = image[8*int'(addr[3:0]) +: 8];
    end else if (addr > 16'hfff6) begin
      data = image[8*int'(4'hf - addr[3:0]) +: 8];
    end else begin
      data = ~addr[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pointer cleared whenever the loader is reset, else the restart misaligns
  always_ff @(posedge clk or negedge oe_reset_n) begin
    if (!oe_reset_n) begin
      ptr    <= 7'h00;
      config_clock_d <= 1'b0;
    end else begin
      config_clock_d <= config_clock;
      if (config_clock_d && !config_clock && ptr < 7'd72) begin
        ptr <= ptr + 7'd1;
      end
    end
  end

  // a disabled memory shows the inverted bit, never the bit the loader wants
  assign sbit  = (ptr < 7'd72) ? image[ptr] : 1'b1;
  assign sdata = ce_n ? ~sbit : sbit;
endmodule : cfgl_mem_model
`default_nettype wire

// *** verification/tb_top.sv ***
// Purpose: self-checking bench of the configuration loader
// Assumes: short config clock and short own payload for run time
// Notes:   up, down, serial and peripheral modes load the same 72-bit stream
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [23:0] LEN = 24'h00_0048;
  localparam logic [35:0] PAY = 36'h9_a5c3_6e1b;
  logic        clk, rst_n, ma, mb, mc, cs_a_n, cs_b_n, cs_c, ws_n, periph;
  logic        config_clock, cc_d, rdy, dout, done_o, sdin;
  logic [7:0]  hdata, mdata;
  logic [15:0] addr;
  logic [71:0] image;
  int          n_errors, check_count;

  cfgl_loader #(.HALF_CYC(4), .OWN_BITS(24'h00_0010)) i_dut (
    .CLK(clk), .RST_N(rst_n), .MODE_SELECT_BIT_A(ma), .MODE_SELECT_BIT_B(mb),
    .MODE_SELECT_BIT_C(mc), .CONFIG_CLOCK(config_clock), .SERIAL_DIN(sdin),
    .MEMORY_ADDRESS_BUS(addr), .BYTE_DATA_BUS(periph ? hdata : mdata),
    .CHIP_SELECT_A_N(cs_a_n), .CHIP_SELECT_B_N(cs_b_n), .CHIP_SELECT_C(cs_c),
    .WRITE_STROBE_N(ws_n), .READY_BUSY(rdy), .SERIAL_DOUT(dout),
    .COMPLETE_PROGRAM_PIN(done_o));

  cfgl_mem_model i_mem (
    .clk(clk), .oe_reset_n(rst_n), .ce_n(1'b0), .config_clock(config_clock), .image(image),
    .addr(addr), .data(mdata), .sdata(sdin));

  ////////////////////////////////////////////////////////////////////////////
  // clock and config clock history for fall detection
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) cc_d <= config_clock;

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // returns just after the first edge with internal reset released
  task automatic do_reset(input logic [2:0] code);
    @(posedge clk);
    rst_n <= 1'b0;
    {ma, mb, mc} <= code;
    periph <= (code == cfgl_pkg::MODE_CODE_PERIPH);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  // header echoed, own payload shown high, then forwarded
  function automatic logic exp_bit(input int i);
    return (i >= 36 && i < 52) ? 1'b1 : image[i];
  endfunction

  task automatic check_stream(input int n);
    int t;
    for (int i = 0; i < n; i++) begin
      for (t = 0; t < 100; t++) begin
        @(negedge clk);
        if (cc_d === 1'b1 && config_clock === 1'b0) break;
      end
      chk("config clock fall", {15'h0, t < 100}, 16'h1);
      chk("chain bit", {15'h0, dout}, {15'h0, exp_bit(i)});
      chk("early complete", {15'h0, done_o}, 16'h0);
    end
  endtask

  task automatic check_done();
    logic c;
    int   t;
    for (t = 0; t < 200 && done_o !== 1'b1; t++) @(negedge clk);
    chk("complete", {15'h0, done_o}, 16'h1);
    c = config_clock;
    repeat (20) @(negedge clk);
    chk("clock stopped", {15'h0, config_clock}, {15'h0, c});
    chk("ready after complete", {15'h0, rdy}, 16'h0);
  endtask

  // one host byte under selects {a_n, b_n, c}; a selected write is followed
  // by a strobe while busy, which must be ignored
  task automatic host_write(input logic [7:0] b, input logic [2:0] sels);
    int   t;
    logic sel;
    sel = (sels == 3'b001);
    for (t = 0; t < 400 && rdy !== 1'b1; t++) @(negedge clk);
    chk("ready before write", {15'h0, rdy}, 16'h1);
    @(posedge clk);
    hdata <= b;
    {cs_a_n, cs_b_n, cs_c} <= sels;
    ws_n  <= 1'b0;
    @(posedge clk);
    ws_n  <= 1'b1;
    {cs_a_n, cs_b_n, cs_c} <= 3'b001;
    @(negedge clk);
    chk("ready after strobe", {15'h0, rdy}, {15'h0, ~sel});
    if (sel) begin
      @(posedge clk);
      hdata <= ~b;
      ws_n  <= 1'b0;
      @(posedge clk);
      ws_n  <= 1'b1;
      @(negedge clk);
      chk("busy held", {15'h0, rdy}, 16'h0);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst_n, ma, mb, mc, cs_a_n, cs_b_n, periph} = 7'h00;
    {cs_c, ws_n} = 2'b11;
    hdata = 8'h00;
    n_errors = 0;
    check_count = 0;
    for (int i = 0; i < 72; i++) begin
      image[i] = (i < 8) ? 1'b1 : (i < 12) ? (i == 10) : (i < 36) ? LEN[35-i] : PAY[i-36];
    end
    for (int c = 2; c < 8; c++) begin
      if (c != 3 && c != 5) begin
        do_reset(3'(c));
        repeat (60) @(negedge clk);
        chk("idle clock", {15'h0, config_clock}, 16'h0);
        chk("idle chain", {15'h0, dout}, 16'h1);
      end
    end
    do_reset(cfgl_pkg::MODE_CODE_UP);
    chk("start address up", addr, cfgl_pkg::ADDR_UP_RST);
    check_stream(71);
    check_done();
    do_reset(cfgl_pkg::MODE_CODE_DOWN);
    chk("start address down", addr, cfgl_pkg::ADDR_DN_RST);
    check_stream(71);
    check_done();
    do_reset(cfgl_pkg::MODE_CODE_SERIAL);
    check_stream(20);
    do_reset(cfgl_pkg::MODE_CODE_SERIAL);
    check_stream(71);
    check_done();
    do_reset(cfgl_pkg::MODE_CODE_PERIPH);
    fork
      for (int k = 0; k < 9; k++) begin
        if (k >= 1 && k <= 3) host_write(~image[8*k +: 8], (k == 1) ? 3'b000 : (k == 2) ? 3'b101 : 3'b011);
        host_write(image[8*k +: 8], 3'b001);
      end
      check_stream(71);
    join
    check_done();
    final_report();
  end

  // watchdog well above the five loads, four of roughly 600 cycles and one short serial load of about 180
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
